// >>> rtl/ccf_top.sv
// contact chatter filter with apb register file
//
// What this block does
// RULE_01: count input changes in initial window; exceeding the limit blocks the input.
// RULE_02: a permissible change limit of zero switches chatter blocking off entirely.
// RULE_03: initial window in seconds starts at the first change of the input.
// RULE_04: at most the set number of tests before permanent block; all-ones means never.
// RULE_05: exceeding in any window starts the idle period in minutes, input blocked.
// RULE_06: idle and subsequent times take effect only with nonzero test count.
// RULE_07: when idle ends a subsequent window in seconds counts changes again.
// RULE_08: subsequent window within the limit releases the input.
// RULE_09: subsequent window over the limit restarts idle until tests are used up.
// RULE_10: one shared parameter set, chatter enable per input.
// RULE_11: protection inputs can never be chatter blocked.
// RULE_12: a blocked input shows a chatter tag plus a general filter indication.
// RULE_13: blocked single point reports asserted if it had been active.
// RULE_14: blocked single point reports deasserted if it had been inactive.
// RULE_15: blocked double point reports the intermediate state.
// RULE_16: each input edge is one change; timers use a common prescaled tick.
// RULE_17: permanent block lasts until reset, a limits or times register write, or clearing the input's enable.
`timescale 1ns/10ps
`default_nettype none
module ccf_top #(
  parameter int unsigned N_IN = 8,
  parameter int unsigned SEC_CYCLES = ccf_pkg::SEC_CYCLES,
  parameter logic [N_IN-1:0] PROT_MASK = '0
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ccf_pkg::APB_AW-1:0] paddr_i,
  input wire logic [ccf_pkg::APB_DW-1:0] pwdata_i,
  output logic [ccf_pkg::APB_DW-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [N_IN-1:0] contact_i,
  output logic [N_IN-1:0] point_state_o,
  output logic [N_IN-1:0] chatter_blocked_tag_o,
  output logic filter_active_o,
  output logic [N_IN-1:0] double_point_o
);
  import ccf_pkg::*;

  localparam int unsigned NP = N_IN / 2;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] perm;
    logic [7:0] tests;
    logic [7:0] t_init;
    logic [7:0] t_sub;
    logic [7:0] t_idle;
    logic [N_IN-1:0] en;
    logic [NP-1:0] dp;
    logic [N_IN-1:0] prev;
    logic [N_IN-1:0] ind;
    logic [N_IN-1:0] blk;
    logic [N_IN-1:0] evt;
    logic [N_IN-1:0] dpo;
    logic [N_IN-1:0][7:0] cnt;
    logic [N_IN-1:0][7:0] tim;
    logic [N_IN-1:0][7:0] used;
    ccf_ch_t [N_IN-1:0] st;
    logic [APB_DW-1:0] rdata;
  } ccf_state_t;

  ccf_state_t q;
  ccf_state_t d;

  logic [N_IN-1:0] in_s;
  logic [N_IN-1:0] chg;
  logic [N_IN-1:0] live;
  logic [N_IN-1:0] locked;
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic cfg_reload;

  ccf_time_if tb ();

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] ccf_sat_inc(input logic [7:0] v);
    return (v == 8'hFF) ? v : v + 8'h01;
  endfunction

  function automatic logic ccf_addr_ok(input logic [APB_AW-1:0] a);
    return (a == OFS_LIMITS) || (a == OFS_TIMES) || (a == OFS_ENABLE) || (a == OFS_DPMODE) ||
           (a == OFS_BLOCKED) || (a == OFS_LOCKED) || (a == OFS_EVENT);
  endfunction

  // ****************************************
  // input sync and timebase
  // ****************************************
  ccf_sync #(
    .W(N_IN)
  ) u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .d_i(contact_i),
    .q_o(in_s)
  );

  ccf_tick #(
    .SEC_CYCLES(SEC_CYCLES)
  ) u_tick (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .tb(tb.src)
  );

  // ****************************************
  // apb decode
  // ****************************************
  assign setup_ph = psel_i & ~penable_i;
  assign access_ph = psel_i & penable_i;
  assign wr_en = access_ph & pwrite_i & ccf_addr_ok(paddr_i);
  assign cfg_reload = wr_en & ((paddr_i == OFS_LIMITS) | (paddr_i == OFS_TIMES)); // RULE_17

  // either edge of the synced input is one change
  assign chg = in_s ^ q.prev; // RULE_16
  assign live = q.en & ~PROT_MASK & {N_IN{q.perm != 8'h00}}; // RULE_02 RULE_10 RULE_11

  always_comb begin
    for (int i = 0; i < N_IN; i++) begin
      locked[i] = (q.st[i] == CH_LOCK);
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    d = q;
    d.prev = in_s;

    for (int i = 0; i < N_IN; i++) begin
      unique case (q.st[i])
        CH_WAIT: begin
          if (chg[i]) begin
            d.st[i] = CH_INIT; // RULE_03
            d.cnt[i] = 8'h01;
            d.tim[i] = q.t_init;
          end
        end
        CH_INIT: begin
          if (chg[i] && (q.cnt[i] >= q.perm)) begin
            if (q.tests == 8'h00) begin
              d.st[i] = CH_LOCK; // RULE_04
            end else begin
              d.st[i] = CH_IDLE; // RULE_01 RULE_05
              d.used[i] = 8'h01;
              d.tim[i] = q.t_idle;
            end
          end else begin
            if (chg[i]) begin
              d.cnt[i] = ccf_sat_inc(q.cnt[i]);
            end
            if (tb.sec_tick) begin
              if (q.tim[i] == 8'h00) begin
                d.st[i] = CH_WAIT;
                d.cnt[i] = 8'h00;
              end else begin
                d.tim[i] = q.tim[i] - 8'h01;
              end
            end
          end
        end
        CH_IDLE: begin
          if (tb.min_tick) begin
            if (q.tim[i] == 8'h00) begin
              d.st[i] = CH_SUB; // RULE_07
              d.cnt[i] = 8'h00;
              d.tim[i] = q.t_sub;
            end else begin
              d.tim[i] = q.tim[i] - 8'h01;
            end
          end
        end
        CH_SUB: begin
          if (chg[i] && (q.cnt[i] >= q.perm)) begin
            if ((q.tests != TESTS_INFINITE) && (q.used[i] >= q.tests)) begin
              d.st[i] = CH_LOCK; // RULE_04
            end else begin
              d.st[i] = CH_IDLE; // RULE_09
              d.used[i] = ccf_sat_inc(q.used[i]);
              d.tim[i] = q.t_idle;
            end
          end else begin
            if (chg[i]) begin
              d.cnt[i] = ccf_sat_inc(q.cnt[i]);
            end
            if (tb.sec_tick && (q.tim[i] == 8'h00)) begin
              d.st[i] = CH_WAIT; // RULE_08
              d.cnt[i] = 8'h00;
              d.used[i] = 8'h00;
            end else if (tb.sec_tick) begin
              d.tim[i] = q.tim[i] - 8'h01;
            end
          end
        end
        CH_LOCK: begin
          d.st[i] = CH_LOCK; // RULE_17
        end
      endcase

      // disabled, protected or reloaded channels restart and pass through
      if (!live[i] || cfg_reload) begin
        d.st[i] = CH_WAIT; // RULE_02 RULE_11 RULE_17
        d.cnt[i] = 8'h00;
        d.used[i] = 8'h00;
        d.tim[i] = 8'h00;
      end

      d.blk[i] = (d.st[i] == CH_IDLE) || (d.st[i] == CH_SUB) || (d.st[i] == CH_LOCK); // RULE_12
      // a blocked point freezes at the level it showed before the change that blocked it
      d.ind[i] = d.blk[i] ? q.ind[i] : in_s[i]; // RULE_13 RULE_14
      if (d.blk[i] && !q.blk[i]) begin
        d.evt[i] = 1'b1; // RULE_12
      end
    end

    // ****************************************
    // register writes
    // ****************************************
    if (wr_en) begin
      unique case (paddr_i)
        OFS_LIMITS: begin
          d.perm = pwdata_i[LIM_PERM_LSB+:FIELD_W];
          d.tests = pwdata_i[LIM_TESTS_LSB+:FIELD_W];
        end
        OFS_TIMES: begin
          d.t_init = pwdata_i[TIM_INIT_LSB+:FIELD_W];
          if (q.tests != 8'h00) begin
            d.t_sub = pwdata_i[TIM_SUB_LSB+:FIELD_W]; // RULE_06
            d.t_idle = pwdata_i[TIM_IDLE_LSB+:FIELD_W]; // RULE_06
          end
        end
        OFS_ENABLE: begin
          d.en = pwdata_i[N_IN-1:0] & ~PROT_MASK; // RULE_10 RULE_11
        end
        OFS_DPMODE: begin
          d.dp = pwdata_i[NP-1:0];
        end
        OFS_EVENT: begin
          // write one to clear, a new event in the same cycle wins
          d.evt = (q.evt & ~pwdata_i[N_IN-1:0]) | (d.blk & ~q.blk);
        end
        default: begin
        end
      endcase
    end

    // pair mode taken after a same-cycle mode write, so output and mode agree
    for (int k = 0; k < NP; k++) begin
      if (d.dp[k] && (d.blk[2*k] || d.blk[2*k+1])) begin
        d.dpo[2*k+:2] = 2'b00; // RULE_15
      end else begin
        d.dpo[2*k+:2] = d.ind[2*k+:2];
      end
    end

    // ****************************************
    // read data, captured in the setup cycle
    // ****************************************
    if (setup_ph) begin
      unique case (paddr_i)
        OFS_LIMITS: d.rdata = {16'h0000, q.tests, q.perm};
        OFS_TIMES: d.rdata = {8'h00, q.t_idle, q.t_sub, q.t_init};
        OFS_ENABLE: d.rdata = APB_DW'(q.en);
        OFS_DPMODE: d.rdata = APB_DW'(q.dp);
        OFS_BLOCKED: d.rdata = APB_DW'(q.blk);
        OFS_LOCKED: d.rdata = APB_DW'(locked);
        OFS_EVENT: d.rdata = APB_DW'(q.evt);
        default: d.rdata = '0;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= '0;
      q.perm <= RST_PERM;
      q.tests <= RST_TESTS;
      q.t_init <= RST_INIT_SECS;
      q.t_sub <= RST_SUB_SECS;
      q.t_idle <= RST_IDLE_MINS;
      for (int i = 0; i < N_IN; i++) begin
        q.st[i] <= CH_WAIT;
      end
    end else begin
      q <= d;
    end
  end

  assign prdata_o = q.rdata;
  assign pready_o = 1'b1;
  assign pslverr_o = access_ph & ~ccf_addr_ok(paddr_i);
  assign point_state_o = q.ind;
  assign chatter_blocked_tag_o = q.blk; // RULE_12
  assign filter_active_o = |q.blk; // RULE_12
  assign double_point_o = q.dpo;

  // ****************************************
  // checks
  // ****************************************
  default clocking ck @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  filter_off_a: assert property ((q.perm == 8'h00) && !wr_en |=> q.blk == '0) // RULE_02
    else $error("blocking seen while filter is off");

  prot_pass_a: assert property ((q.blk & PROT_MASK) == '0) // RULE_11
    else $error("protection input was blocked");

  general_flag_a: assert property (filter_active_o == (chatter_blocked_tag_o != '0)) // RULE_12
    else $error("general chatter flag disagrees with tags");

  for (genvar g = 0; g < N_IN; g++) begin : g_chk
    init_exceed_a: assert property ( // RULE_01
      (q.st[g] == CH_INIT) && live[g] && chg[g] && (q.cnt[g] >= q.perm) && !cfg_reload |=> q.blk[g])
      else $error("limit exceeded without blocking");

    window_start_a: assert property ( // RULE_03
      (q.st[g] == CH_WAIT) && live[g] && chg[g] && !cfg_reload |=> (q.st[g] == CH_INIT) && (q.tim[g] == q.t_init))
      else $error("initial window not started on first change");

    zero_tests_a: assert property ( // RULE_04
      (q.st[g] == CH_INIT) && live[g] && chg[g] && (q.cnt[g] >= q.perm) && (q.tests == 8'h00) && !cfg_reload
      |=> q.st[g] == CH_LOCK)
      else $error("zero test budget did not lock");

    idle_load_a: assert property ( // RULE_05
      $rose(q.blk[g]) && (q.st[g] == CH_IDLE) |-> q.tim[g] == $past(q.t_idle))
      else $error("idle period not loaded");

    idle_end_a: assert property ( // RULE_07
      (q.st[g] == CH_IDLE) && tb.min_tick && (q.tim[g] == 8'h00) && live[g] && !cfg_reload
      |=> (q.st[g] == CH_SUB) && (q.cnt[g] == 8'h00))
      else $error("subsequent window did not open");

    sub_release_a: assert property ( // RULE_08
      (q.st[g] == CH_SUB) && tb.sec_tick && (q.tim[g] == 8'h00) && !(chg[g] && (q.cnt[g] >= q.perm))
      |=> !q.blk[g] ##1 !q.blk[g] || chg[g])
      else $error("input not released after quiet window");

    sub_retry_a: assert property ( // RULE_09
      (q.st[g] == CH_SUB) && live[g] && chg[g] && (q.cnt[g] >= q.perm) && (q.tests == TESTS_INFINITE) && !cfg_reload
      |=> q.st[g] == CH_IDLE)
      else $error("infinite budget still locked");

    lock_hold_a: assert property ( // RULE_17
      (q.st[g] == CH_LOCK) && live[g] && !cfg_reload |=> q.st[g] == CH_LOCK)
      else $error("locked input released on its own");

    hold_level_a: assert property ( // RULE_13
      q.blk[g] && $past(q.blk[g]) |-> $stable(point_state_o[g]))
      else $error("blocked point state moved");

    pass_level_a: assert property ( // RULE_14
      !q.blk[g] |-> point_state_o[g] == $past(in_s[g]))
      else $error("released point does not follow input");
  end

  for (genvar k = 0; k < NP; k++) begin : g_dp
    dp_mid_a: assert property ( // RULE_15
      q.dp[k] && (q.blk[2*k] || q.blk[2*k+1]) |-> double_point_o[2*k+:2] == 2'b00)
      else $error("blocked double point not intermediate");
  end
endmodule
`default_nettype wire

// >>> rtl/ccf_pkg.sv
// constants, register map and types of the contact chatter filter
package ccf_pkg;

  // ****************************************
  // timebase
  // ****************************************
  localparam int unsigned CLK_FREQ_HZ = 25_000_000;
  localparam int unsigned TICK_PERIOD_MS = 1000;
  localparam int unsigned SEC_CYCLES = CLK_FREQ_HZ / 1000 * TICK_PERIOD_MS;
  localparam int unsigned SECS_PER_MIN = 60;

  // ****************************************
  // register map
  // ****************************************
  localparam int unsigned APB_AW = 8;
  localparam int unsigned APB_DW = 32;
  localparam logic [7:0] OFS_LIMITS = 8'h00;
  localparam logic [7:0] OFS_TIMES = 8'h04;
  localparam logic [7:0] OFS_ENABLE = 8'h08;
  localparam logic [7:0] OFS_DPMODE = 8'h0C;
  localparam logic [7:0] OFS_BLOCKED = 8'h10;
  localparam logic [7:0] OFS_LOCKED = 8'h14;
  localparam logic [7:0] OFS_EVENT = 8'h18;

  // ****************************************
  // field layout
  // ****************************************
  localparam int unsigned FIELD_W = 8;
  localparam int unsigned LIM_PERM_LSB = 0;
  localparam int unsigned LIM_TESTS_LSB = 8;
  localparam int unsigned TIM_INIT_LSB = 0;
  localparam int unsigned TIM_SUB_LSB = 8;
  localparam int unsigned TIM_IDLE_LSB = 16;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_PERM = 8'h00;
  localparam logic [7:0] RST_TESTS = 8'h04;
  localparam logic [7:0] RST_INIT_SECS = 8'h01;
  localparam logic [7:0] RST_SUB_SECS = 8'h0A;
  localparam logic [7:0] RST_IDLE_MINS = 8'h01;
  localparam logic [7:0] TESTS_INFINITE = 8'hFF;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {CH_WAIT, CH_INIT, CH_IDLE, CH_SUB, CH_LOCK} ccf_ch_t;

endpackage

// >>> rtl/ccf_time_if.sv
// common prescaled second and minute ticks
`timescale 1ns/10ps
`default_nettype none
interface ccf_time_if;
  logic sec_tick;
  logic min_tick;
  modport src (output sec_tick, output min_tick);
  modport snk (input sec_tick, input min_tick);
endinterface
`default_nettype wire

// >>> rtl/ccf_sync.sv
// two flip-flop synchroniser for the contact inputs
`timescale 1ns/10ps
`default_nettype none
module ccf_sync #(
  parameter int unsigned W = 8
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } ccf_sync_t;

  ccf_sync_t q;
  ccf_sync_t d;

  always_comb begin
    d = q;
    d.meta = d_i;
    d.sync = q.meta;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign q_o = q.sync;
endmodule
`default_nettype wire

// >>> rtl/ccf_tick.sv
// prescaler making the second and minute ticks
`timescale 1ns/10ps
`default_nettype none
module ccf_tick #(
  parameter int unsigned SEC_CYCLES = ccf_pkg::SEC_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  ccf_time_if.src tb
);
  import ccf_pkg::*;
  localparam int unsigned CW = (SEC_CYCLES > 1) ? $clog2(SEC_CYCLES) : 1;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [5:0] secs;
    logic sec;
    logic min;
  } ccf_tick_t;

  ccf_tick_t q;
  ccf_tick_t d;

  always_comb begin
    d = q;
    d.sec = 1'b0;
    d.min = 1'b0;
    if (q.cnt == CW'(SEC_CYCLES - 1)) begin
      d.cnt = '0;
      d.sec = 1'b1;
      if (q.secs == 6'(SECS_PER_MIN - 1)) begin
        d.secs = '0;
        d.min = 1'b1;
      end else begin
        d.secs = q.secs + 6'h01;
      end
    end else begin
      d.cnt = q.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tb.sec_tick = q.sec;
  assign tb.min_tick = q.min;
endmodule
`default_nettype wire

// >>> testbench/ccf_contacts.sv
// contact model: steady levels or continuous chatter per input
`timescale 1ns/10ps
`default_nettype none
module ccf_contacts (
  input wire logic clk_i,
  input wire logic [7:0] level_i,
  input wire logic [7:0] bounce_i,
  output logic [7:0] contact_o
);
  logic [2:0] div_q = 3'h0;
  logic osc_q = 1'b0;

  // ****************************************
  // chatter source, one change every 8 clocks
  // ****************************************
  always @(posedge clk_i) begin
    div_q <= div_q + 3'h1;
    if (div_q == 3'h7) begin
      osc_q <= ~osc_q;
    end
  end

  // bouncing inputs follow the oscillator, the rest hold their level
  assign contact_o = (level_i & ~bounce_i) | ({8{osc_q}} & bounce_i);
endmodule
`default_nettype wire

// >>> testbench/contact_chatter_filter_bench.sv
// self-checking bench of the contact chatter filter
`timescale 1ns/10ps
`default_nettype none
module contact_chatter_filter_bench;
  import ccf_pkg::*;
  localparam int unsigned SEC = 20;

  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [7:0] contact;
  logic [7:0] point_state_o;
  logic [7:0] chatter_blocked_tag_o;
  logic filter_active_o;
  logic [7:0] double_point_o;
  logic [7:0] level_q = 8'h00;
  logic [7:0] bounce_q = 8'h00;
  logic [31:0] rnd;
  logic [32:0] exp_q[$];
  int num_errors = 0;
  int n_compared = 0;
  int seed = 76394;

  always #20 clk_i = ~clk_i;

  ccf_contacts i_contacts (.clk_i(clk_i), .level_i(level_q), .bounce_i(bounce_q), .contact_o(contact));

  ccf_top #(.N_IN(8), .SEC_CYCLES(SEC), .PROT_MASK(8'h80)) i_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .contact_i(contact), .point_state_o(point_state_o),
    .chatter_blocked_tag_o(chatter_blocked_tag_o), .filter_active_o(filter_active_o),
    .double_point_o(double_point_o)
  );

  // ****************************************
  // reporting
  // ****************************************
  task automatic final_report();
    $display("mismatches %0d, comparisons %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // ****************************************
  // apb master, one idle cycle between transfers
  // ****************************************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    if (!wr) begin
      exp_q.push_back(e);
    end
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      final_report();
    end
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask

  // read results are compared against the oldest note
  always @(posedge clk_i) begin
    if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i) begin
      if (exp_q.size() == 0) begin
        num_errors++;
      end else begin
        chk({pslverr_o, prdata_o}, exp_q.pop_front());
      end
    end
  end

  // ****************************************
  // contact stimulus and bounded waits
  // ****************************************
  task automatic edges(input logic [7:0] m, input int cnt);
    repeat (cnt) begin
      level_q <= level_q ^ m;
      cycles(6);
    end
  endtask

  task automatic wait_tag(input int b, input logic v, input int lim);
    int n;
    n = 0;
    while (chatter_blocked_tag_o[b] !== v && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= lim) begin
      num_errors++;
      $display("wait for tag %0d ran out at %0t", b, $time);
      final_report();
    end
  endtask

  initial begin
    cycles(20000);
    num_errors++;
    $display("run time limit reached");
    final_report();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    cycles(6);
    reset_n_i <= 1'b1;
    cycles(1);
    rd(OFS_LIMITS, {17'h0, RST_TESTS, RST_PERM});
    rd(OFS_TIMES, {9'h0, RST_IDLE_MINS, RST_SUB_SECS, RST_INIT_SECS});
    rd(8'h1C, 33'h1_0000_0000);
    wr(OFS_BLOCKED, 32'hFFFF_FFFF);
    rd(OFS_BLOCKED, 33'h0);
    $display("test reset values done");
    // filter off: random contacts always pass
    wr(OFS_ENABLE, 32'h0000_00FF);
    rd(OFS_ENABLE, 33'h0_0000_007F);
    repeat (20) begin
      rnd = $random(seed);
      level_q <= rnd[7:0];
      cycles(6);
      chk({25'h0, point_state_o}, {25'h0, level_q});
      chk({25'h0, chatter_blocked_tag_o}, 33'h0);
    end
    $display("test filter off done");
    // block input 0 while active and input 1 while inactive
    level_q <= 8'h01;
    wr(OFS_LIMITS, 32'h0000_0202);
    wr(OFS_TIMES, 32'h0001_0102);
    rd(OFS_TIMES, 33'h0_0001_0102);
    wr(OFS_ENABLE, 32'h0000_0003);
    wr(OFS_DPMODE, 32'h0000_0001);
    edges(8'h03, 2);
    chk({31'h0, chatter_blocked_tag_o[1:0]}, 33'h0);
    edges(8'h03, 1);
    chk({31'h0, chatter_blocked_tag_o[1:0]}, 33'h3);
    chk({32'h0, filter_active_o}, 33'h1);
    chk({32'h0, point_state_o[0]}, 33'h1);
    chk({32'h0, point_state_o[1]}, 33'h0);
    chk({31'h0, double_point_o[1:0]}, 33'h0);
    chk({31'h0, double_point_o[5:4]}, {31'h0, level_q[5:4]});
    rd(OFS_BLOCKED, 33'h3);
    rd(OFS_EVENT, 33'h3);
    wr(OFS_EVENT, 32'h0000_0003);
    rd(OFS_EVENT, 33'h0);
    $display("test initial window done");
    // input 0 keeps chattering, input 1 stays quiet
    bounce_q <= 8'h01;
    wait_tag(1, 1'b0, 3000);
    cycles(4);
    chk({32'h0, point_state_o[1]}, {32'h0, level_q[1]});
    chk({32'h0, chatter_blocked_tag_o[0]}, 33'h1);
    rd(OFS_LOCKED, 33'h0);
    cycles(2500);
    bounce_q <= 8'h00;
    rd(OFS_LOCKED, 33'h1);
    cycles(100);
    chk({32'h0, chatter_blocked_tag_o[0]}, 33'h1);
    wr(OFS_LIMITS, 32'h0000_0202);
    cycles(4);
    chk({25'h0, chatter_blocked_tag_o}, 33'h0);
    rd(OFS_LOCKED, 33'h0);
    $display("test subsequent windows done");
    // zero test budget: times partly ignored, first exceed locks
    wr(OFS_LIMITS, 32'h0000_0002);
    wr(OFS_TIMES, 32'h0005_0603);
    rd(OFS_TIMES, 33'h0_0001_0103);
    wr(OFS_ENABLE, 32'h0000_0007);
    edges(8'h04, 3);
    rd(OFS_LOCKED, 33'h4);
    chk({32'h0, filter_active_o}, 33'h1);
    $display("test zero budget done");
    // infinite budget: a failed subsequent window restarts idle, never locks
    wr(OFS_LIMITS, 32'h0000_FF01);
    wr(OFS_ENABLE, 32'h0000_0008);
    bounce_q <= 8'h08;
    cycles(2600);
    rd(OFS_LOCKED, 33'h0);
    rd(OFS_BLOCKED, 33'h8);
    bounce_q <= 8'h00;
    $display("test infinite budget done");
    final_report();
  end
endmodule
`default_nettype wire
